// file: gsi_pkg.sv
// constants for the group management interrupt and either-edge block
package gsi_pkg;

   // register offsets, relative to the power management base
   localparam logic [7:0] GSI_OFF_ENABLE_A = 8'h14;
   localparam logic [7:0] GSI_OFF_ENABLE_B = 8'h15;
   localparam logic [7:0] GSI_OFF_EDGE_STS = 8'h16;

   // reset values, taken on battery power-on
   localparam logic [7:0] GSI_RST_ENABLE_A = 8'h00;
   localparam logic [7:0] GSI_RST_ENABLE_B = 8'h00;
   localparam logic [7:0] GSI_RST_EDGE_STS = 8'h00;

   // enable register a field positions
   localparam int GSI_A_RING = 0;
   localparam int GSI_A_PARALLEL = 1;
   localparam int GSI_A_UART_B = 2;
   localparam int GSI_A_UART_A = 3;
   localparam int GSI_A_FLOPPY = 4;
   localparam int GSI_A_GPIO_GROUP_B = 5;
   localparam int GSI_A_GPIO_GROUP_A = 6;
   localparam int GSI_A_WATCHDOG = 7;

   // enable register b field positions
   localparam int GSI_B_MOUSE = 0;
   localparam int GSI_B_KEYBOARD = 1;
   localparam int GSI_B_INFRARED = 2;
   localparam int GSI_B_BSRC = 3;
   localparam int GSI_B_KBC_ROUTE = 4;
   localparam int GSI_B_TO_WAKE = 6;
   localparam int GSI_B_OUT_EN = 7;

   // writable bits of enable register b; bit 5 is reserved
   localparam logic [7:0] GSI_ENABLE_B_MASK = 8'hdf;

   // edge status field positions
   localparam int GSI_S_EDGE_LSB = 0;
   localparam int GSI_S_STANDBY_POR = 4;
   localparam logic [7:0] GSI_EDGE_STS_MASK = 8'h1f;

   // number of either-edge pins
   localparam int GSI_EDGE_PINS = 4;

   // register index type for the read mux
   typedef enum logic [1:0] {
      GSI_SEL_NONE = 2'b00,
      GSI_SEL_ENABLE_A = 2'b01,
      GSI_SEL_ENABLE_B = 2'b10,
      GSI_SEL_EDGE_STS = 2'b11
   } gsi_sel_t;

endpackage : gsi_pkg

// file: gsi_group_irq.sv
// group management interrupt gathering and either-edge gpio detection
//
// How it works
// - enable register a gates eight sources
// - enable register b gates four more sources
// - ring uses wake ring status directly
// - b bit4 routes keyboard controller port bit
// - b bit6 feeds group into wake logic
// - b bit7 drives pin or frame slot
// - mux select bit picks pin or frame
// - four gpio pins interrupt on both edges
// - edge mode needs its group enabled
// - edge mode ignores direction, polarity, drive type
// - polarity still inverts reported data bit
// - edge interrupt needs status and enable
// - status records edges regardless of enables
// - status bits 0-3 follow pins 11,12,53,54
// - write one clears status, zero keeps
// - bit4 sets on standby power-on reset
// - power-on after standby reset raises sci
// - status bits 5-7 read zero
// - group is or of enabled active sources and ungated other events
`timescale 1ns/10ps
`default_nettype none

module gsi_group_irq
   import gsi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port, already qualified by the base decode
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // interrupt sources, levels from logic on this clock
   input wire logic ring_wake_status,
   input wire logic parallel_irq,
   input wire logic uart_b_irq,
   input wire logic uart_a_irq,
   input wire logic floppy_irq,
   input wire logic gpio_group_b_irq,
   input wire logic gpio_group_a_irq,
   input wire logic watchdog_irq,
   input wire logic mouse_irq,
   input wire logic keyboard_irq,
   input wire logic infrared_irq,
   input wire logic b_source_irq,
   input wire logic kbc_port_bit,
   input wire logic other_mgmt_events,
   input wire logic irq_mux_frame_sel,
   // gpio control, from the gpio configuration on this clock
   input wire logic [3:0] either_edge_select,
   input wire logic [3:0] gpio_polarity,
   input wire logic [3:0] gpio_dir_out,
   input wire logic [3:0] gpio_open_drain,
   input wire logic [3:0] gpio_out_value,
   // gpio pins 11, 12, 53, 54 in bit order 0..3
   input wire logic gpio_pin_11,
   input wire logic gpio_pin_12,
   input wire logic gpio_pin_53,
   input wire logic gpio_pin_54,
   input wire logic standby_por,
   input wire logic system_power_on_out_n,
   // outputs
   output logic group_mgmt_irq_out_n,
   output logic group_mgmt_irq_oe,
   output logic frame_slot_irq,
   output logic group_to_wake,
   output logic sci_pulse,
   output logic [3:0] either_edge_irq,
   output logic [3:0] gpio_data,
   output logic [3:0] gpio_pin_oe,
   output logic [3:0] gpio_pin_out
);

   // address decode, shared by the write and read paths
   function automatic gsi_sel_t decode(input logic [7:0] addr);
      unique case (addr)
         GSI_OFF_ENABLE_A: decode = GSI_SEL_ENABLE_A;
         GSI_OFF_ENABLE_B: decode = GSI_SEL_ENABLE_B;
         GSI_OFF_EDGE_STS: decode = GSI_SEL_EDGE_STS;
         default: decode = GSI_SEL_NONE;
      endcase
   endfunction : decode

   gsi_sel_t sel;
   logic [3:0] pin_raw;
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   logic [3:0] pin_prev_reg;
   logic [3:0] pin_meta_next;
   logic [3:0] pin_sync_next;
   logic [3:0] pin_prev_next;
   logic [3:0] edge_seen;
   logic [3:0] edge_mode;
   logic por_meta_reg;
   logic por_sync_reg;
   logic por_prev_reg;
   logic pwr_meta_reg;
   logic pwr_sync_reg;
   logic pwr_prev_reg;
   logic [7:0] enable_a_reg;
   logic [7:0] enable_b_reg;
   logic [7:0] edge_sts_reg;
   logic [7:0] enable_a_next;
   logic [7:0] enable_b_next;
   logic [7:0] edge_sts_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [1:0] group_en;
   logic [3:0] edge_irq;
   logic [7:0] src_a;
   logic [3:0] src_b;
   logic group_active;
   logic out_n_reg;
   logic oe_reg;
   logic slot_reg;
   logic wake_reg;
   logic sci_reg;
   logic [3:0] eirq_reg;
   logic [3:0] data_reg;
   logic [3:0] poe_reg;
   logic [3:0] pout_reg;
   logic out_n_next;
   logic oe_next;
   logic slot_next;
   logic wake_next;
   logic sci_next;
   logic [3:0] data_next;
   logic [3:0] poe_next;
   logic [3:0] pout_next;

   assign sel = decode(reg_addr);
   assign pin_raw = {gpio_pin_54, gpio_pin_53, gpio_pin_12, gpio_pin_11};

   // two-stage synchronisers; data uses the second stage, edges compare it with a third
   always_comb begin
      pin_meta_next = pin_raw;
      pin_sync_next = pin_meta_reg;
      pin_prev_next = pin_sync_reg;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // pins reset low: a pin already high at release reports one edge
         pin_meta_reg <= 4'h0;
         pin_sync_reg <= 4'h0;
         pin_prev_reg <= 4'h0;
      end else begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
         pin_prev_reg <= pin_prev_next;
      end
   end

   // standby reset and power-on pin cross in from other domains
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         por_meta_reg <= 1'b0;
         por_sync_reg <= 1'b0;
         por_prev_reg <= 1'b0;
         // power-on pin resets to its idle high level, so no false sci
         pwr_meta_reg <= 1'b1;
         pwr_sync_reg <= 1'b1;
         pwr_prev_reg <= 1'b1;
      end else begin
         por_meta_reg <= standby_por;
         por_sync_reg <= por_meta_reg;
         por_prev_reg <= por_sync_reg;
         pwr_meta_reg <= system_power_on_out_n;
         pwr_sync_reg <= pwr_meta_reg;
         pwr_prev_reg <= pwr_sync_reg;
      end
   end

   // per pin: edge, gated interrupt, data bit and pin drive
   assign group_en[0] = enable_a_reg[GSI_A_GPIO_GROUP_A];
   assign group_en[1] = enable_a_reg[GSI_A_GPIO_GROUP_B];

   generate
      for (genvar i = 0; i < GSI_EDGE_PINS; i++) begin : g_pin
         // both edges count, independent of polarity
         assign edge_seen[i] = pin_sync_reg[i] ^ pin_prev_reg[i];
         // pins 0,1 belong to group a, pins 2,3 to group b; no group, no mode
         assign edge_mode[i] = either_edge_select[i] & group_en[i / 2];
         assign edge_irq[i] = edge_sts_reg[GSI_S_EDGE_LSB + i] & edge_mode[i];
      end
   endgenerate

   always_comb begin
      data_next = pin_sync_reg ^ gpio_polarity;
      // in edge mode the pin is a plain input, whatever the control bits say
      // a pin whose group is disabled keeps its normal drive
      poe_next = gpio_dir_out & ~edge_mode;
      pout_next = 4'h0;
      for (int i = 0; i < GSI_EDGE_PINS; i++) begin
         // open drain drives only when the value is zero; push-pull drives both levels
         if (gpio_open_drain[i] && gpio_out_value[i]) begin
            poe_next[i] = 1'b0;
         end
         pout_next[i] = gpio_out_value[i] ^ gpio_polarity[i];
         if (edge_mode[i]) begin
            pout_next[i] = 1'b0;
         end
      end
   end

   // register writes; hardware set beats a software clear
   always_comb begin
      enable_a_next = enable_a_reg;
      enable_b_next = enable_b_reg;
      edge_sts_next = edge_sts_reg;
      if (reg_wr && sel == GSI_SEL_ENABLE_A) begin
         enable_a_next = reg_wdata;
      end
      if (reg_wr && sel == GSI_SEL_ENABLE_B) begin
         enable_b_next = reg_wdata & GSI_ENABLE_B_MASK;
      end
      if (reg_wr && sel == GSI_SEL_EDGE_STS) begin
         edge_sts_next = edge_sts_reg & ~reg_wdata;
      end
      // an edge and a clear in one cycle leave the bit set, so no edge is lost
      // edges set status whether or not anything is enabled
      edge_sts_next[GSI_S_EDGE_LSB +: GSI_EDGE_PINS] =
         edge_sts_next[GSI_S_EDGE_LSB +: GSI_EDGE_PINS] | edge_seen;
      if (por_sync_reg && !por_prev_reg) begin
         edge_sts_next[GSI_S_STANDBY_POR] = 1'b1;
      end
      edge_sts_next = edge_sts_next & GSI_EDGE_STS_MASK;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_a_reg <= GSI_RST_ENABLE_A;
         enable_b_reg <= GSI_RST_ENABLE_B;
         edge_sts_reg <= GSI_RST_EDGE_STS;
      end else begin
         enable_a_reg <= enable_a_next;
         enable_b_reg <= enable_b_next;
         edge_sts_reg <= edge_sts_next;
      end
   end

   // read data is registered, so it appears the edge after the strobe
   // there is no valid flag: the host takes data a fixed cycle later
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         unique case (sel)
            GSI_SEL_ENABLE_A: rdata_next = enable_a_reg;
            GSI_SEL_ENABLE_B: rdata_next = enable_b_reg;
            GSI_SEL_EDGE_STS: rdata_next = edge_sts_reg & GSI_EDGE_STS_MASK;
            GSI_SEL_NONE: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // source vectors in enable register bit order
   always_comb begin
      src_a = 8'h00;
      src_a[GSI_A_RING] = ring_wake_status;
      src_a[GSI_A_PARALLEL] = parallel_irq;
      src_a[GSI_A_UART_B] = uart_b_irq;
      src_a[GSI_A_UART_A] = uart_a_irq;
      src_a[GSI_A_FLOPPY] = floppy_irq;
      // edge interrupts join their combined gpio group
      src_a[GSI_A_GPIO_GROUP_B] = gpio_group_b_irq | edge_irq[2] | edge_irq[3];
      src_a[GSI_A_GPIO_GROUP_A] = gpio_group_a_irq | edge_irq[0] | edge_irq[1];
      src_a[GSI_A_WATCHDOG] = watchdog_irq;
      src_b = 4'h0;
      src_b[GSI_B_MOUSE] = mouse_irq;
      src_b[GSI_B_KEYBOARD] = keyboard_irq;
      src_b[GSI_B_INFRARED] = infrared_irq;
      src_b[GSI_B_BSRC] = b_source_irq;
   end

   // group is the or of every enabled active source, plus other_mgmt_events with no enable
   assign group_active = (|(src_a & enable_a_reg))
                         | (|(src_b & enable_b_reg[3:0]))
                         | (kbc_port_bit & enable_b_reg[GSI_B_KBC_ROUTE])
                         | other_mgmt_events;

   // output stage; all outputs registered for clean pins
   // costs one cycle of latency, but the pins never glitch
   always_comb begin
      oe_next = enable_b_reg[GSI_B_OUT_EN] & ~irq_mux_frame_sel;
      // pin floats high-side when disabled; level only matters with oe set
      out_n_next = ~(group_active & enable_b_reg[GSI_B_OUT_EN]);
      slot_next = group_active & enable_b_reg[GSI_B_OUT_EN] & irq_mux_frame_sel;
      wake_next = group_active & enable_b_reg[GSI_B_TO_WAKE];
      // sci only when power comes on while the standby flag is up
      sci_next = pwr_prev_reg & ~pwr_sync_reg
                 & edge_sts_reg[GSI_S_STANDBY_POR];
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_n_reg <= 1'b1;
         oe_reg <= 1'b0;
         slot_reg <= 1'b0;
         wake_reg <= 1'b0;
         sci_reg <= 1'b0;
         eirq_reg <= 4'h0;
         data_reg <= 4'h0;
         poe_reg <= 4'h0;
         pout_reg <= 4'h0;
      end else begin
         out_n_reg <= out_n_next;
         oe_reg <= oe_next;
         slot_reg <= slot_next;
         wake_reg <= wake_next;
         sci_reg <= sci_next;
         eirq_reg <= edge_irq;
         data_reg <= data_next;
         poe_reg <= poe_next;
         pout_reg <= pout_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign group_mgmt_irq_out_n = out_n_reg;
   assign group_mgmt_irq_oe = oe_reg;
   assign frame_slot_irq = slot_reg;
   assign group_to_wake = wake_reg;
   assign sci_pulse = sci_reg;
   assign either_edge_irq = eirq_reg;
   assign gpio_data = data_reg;
   assign gpio_pin_oe = poe_reg;
   assign gpio_pin_out = pout_reg;

endmodule : gsi_group_irq

`default_nettype wire

// file: gsi_group_irq_sva.sv
// assertion checker for the group interrupt block
`timescale 1ns/10ps
`default_nettype none
module gsi_group_irq_sva
   import gsi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic ring_wake_status,
   input wire logic parallel_irq,
   input wire logic uart_b_irq,
   input wire logic uart_a_irq,
   input wire logic floppy_irq,
   input wire logic gpio_group_b_irq,
   input wire logic gpio_group_a_irq,
   input wire logic watchdog_irq,
   input wire logic mouse_irq,
   input wire logic keyboard_irq,
   input wire logic infrared_irq,
   input wire logic b_source_irq,
   input wire logic kbc_port_bit,
   input wire logic other_mgmt_events,
   input wire logic irq_mux_frame_sel,
   input wire logic [3:0] either_edge_select,
   input wire logic [3:0] gpio_polarity,
   input wire logic gpio_pin_11,
   input wire logic group_mgmt_irq_out_n,
   input wire logic group_mgmt_irq_oe,
   input wire logic frame_slot_irq,
   input wire logic group_to_wake,
   input wire logic sci_pulse,
   input wire logic [3:0] either_edge_irq,
   input wire logic [3:0] gpio_data,
   input wire logic [3:0] gpio_pin_oe
);
   logic [7:0] en_a_reg;
   logic [7:0] en_b_reg;
   logic grp;
   // shadow enables, updated on the same edge as the design's own
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         en_a_reg <= 8'h00;
         en_b_reg <= 8'h00;
      end else if (reg_wr && reg_addr == GSI_OFF_ENABLE_A) begin
         en_a_reg <= reg_wdata;
      end else if (reg_wr && reg_addr == GSI_OFF_ENABLE_B) begin
         en_b_reg <= reg_wdata & GSI_ENABLE_B_MASK;
      end
   end
   // expected group level, before the output gate
   assign grp = (|(en_a_reg & {watchdog_irq, gpio_group_a_irq, gpio_group_b_irq, floppy_irq,
      uart_a_irq, uart_b_irq, parallel_irq, ring_wake_status})) | other_mgmt_events
      | (|(en_b_reg[4:0] & {kbc_port_bit, b_source_irq, infrared_irq, keyboard_irq,
      mouse_irq}));
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   // pin and polarity held long enough to cross the sync chain
   sequence s_pin_steady;
      ($stable(gpio_pin_11) && $stable(gpio_polarity[0])) [*4];
   endsequence
   sequence s_edge_armed;
      $rose(gpio_pin_11) && either_edge_select[0] && en_a_reg[GSI_A_GPIO_GROUP_A];
   endsequence
   AST_PIN_FLOAT: assert property (
      !en_b_reg[GSI_B_OUT_EN] |=> group_mgmt_irq_out_n && !group_mgmt_irq_oe)
      else $error("group pin driven while output disabled");
   AST_PIN_DRIVE: assert property (
      grp && en_b_reg[GSI_B_OUT_EN] && !irq_mux_frame_sel
      |=> !group_mgmt_irq_out_n && group_mgmt_irq_oe)
      else $error("group pin not asserted");
   AST_SLOT: assert property (
      grp && en_b_reg[GSI_B_OUT_EN] && irq_mux_frame_sel |=> frame_slot_irq)
      else $error("frame slot not asserted");
   AST_WAKE_ON: assert property (
      grp && en_b_reg[GSI_B_TO_WAKE] |=> group_to_wake)
      else $error("group not fed to wake logic");
   AST_WAKE_OFF: assert property (
      !(grp && en_b_reg[GSI_B_TO_WAKE]) && !en_a_reg[GSI_A_GPIO_GROUP_A]
      && !en_a_reg[GSI_A_GPIO_GROUP_B] |=> !group_to_wake)
      else $error("wake fed without enabled group");
   AST_EDGE_GATE: assert property (
      either_edge_irq[0] |-> $past(either_edge_select[0]) && $past(en_a_reg[6]))
      else $error("edge interrupt without select and group enable");
   AST_EDGE_SET: assert property (
      s_edge_armed |-> ##[2:5] either_edge_irq[0])
      else $error("edge on first pin not reported");
   AST_DATA: assert property (
      s_pin_steady |-> gpio_data[0] == (gpio_pin_11 ^ gpio_polarity[0]))
      else $error("pin data not polarity adjusted");
   AST_NO_DRIVE: assert property (
      either_edge_select[0] && en_a_reg[GSI_A_GPIO_GROUP_A] |=> !gpio_pin_oe[0])
      else $error("edge mode pin still driven");
   AST_RSVD_ZERO: assert property (
      reg_rd && reg_addr == GSI_OFF_EDGE_STS |=> reg_rdata[7:5] == 3'h0)
      else $error("reserved status bits not zero");
   AST_SCI_PULSE: assert property (
      sci_pulse |=> !sci_pulse)
      else $error("sci longer than one cycle");
endmodule : gsi_group_irq_sva
bind gsi_group_irq gsi_group_irq_sva chk_u (.ref_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .ring_wake_status, .parallel_irq, .uart_b_irq, .uart_a_irq,
   .floppy_irq, .gpio_group_b_irq, .gpio_group_a_irq, .watchdog_irq, .mouse_irq,
   .keyboard_irq, .infrared_irq, .b_source_irq, .kbc_port_bit, .other_mgmt_events,
   .irq_mux_frame_sel, .either_edge_select, .gpio_polarity, .gpio_pin_11,
   .group_mgmt_irq_out_n, .group_mgmt_irq_oe, .frame_slot_irq, .group_to_wake, .sci_pulse,
   .either_edge_irq, .gpio_data, .gpio_pin_oe);
`default_nettype wire

// file: gsi_host_model.sv
// host-side receiver of the group management interrupt
`timescale 1ns/10ps
`default_nettype none
module gsi_host_model (
   input wire logic ref_clk,
   input wire logic group_mgmt_irq_out_n,
   input wire logic group_mgmt_irq_oe,
   input wire logic frame_slot_irq,
   output logic pin_level,
   output logic smi_taken_reg
);
   // board pull-up: a floating pin reads high, never the last value
   assign pin_level = group_mgmt_irq_oe ? group_mgmt_irq_out_n : 1'b1;
   // host takes the interrupt from the pin or the frame slot
   always_ff @(posedge ref_clk) begin
      smi_taken_reg <= !pin_level || frame_slot_irq;
   end
endmodule : gsi_host_model
`default_nettype wire

// file: gsi_group_irq_test.sv
// self-checking testbench for the group interrupt block
`timescale 1ns/10ps
`default_nettype none
module gsi_group_irq_test import gsi_pkg::*;;
   logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [12:0] src = 13'h0;
   logic [3:0] pin = 4'h0, sel = 4'h0, pol = 4'h0, either_edge_irq, gpio_data, gpio_pin_oe;
   logic [3:0] gpio_pin_out;
   logic other = 1'b0, fsel = 1'b0, por = 1'b0, pwr_n = 1'b1, pin_level, smi_taken_reg;
   logic group_mgmt_irq_out_n, group_mgmt_irq_oe, frame_slot_irq, group_to_wake, sci_pulse;
   int error_cnt = 0, tests_run = 0, i, k;
   always #25 ref_clk = ~ref_clk;
   // direction and drive tied on: edge mode must override them
   gsi_group_irq dut_u (.ref_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .ring_wake_status(src[0]), .parallel_irq(src[1]), .uart_b_irq(src[2]),
      .uart_a_irq(src[3]), .floppy_irq(src[4]), .gpio_group_b_irq(src[5]),
      .gpio_group_a_irq(src[6]), .watchdog_irq(src[7]), .mouse_irq(src[8]),
      .keyboard_irq(src[9]), .infrared_irq(src[10]), .b_source_irq(src[11]),
      .kbc_port_bit(src[12]), .other_mgmt_events(other), .irq_mux_frame_sel(fsel),
      .either_edge_select(sel), .gpio_polarity(pol), .gpio_dir_out(4'hf),
      .gpio_open_drain(4'h0), .gpio_out_value(4'hf), .gpio_pin_11(pin[0]),
      .gpio_pin_12(pin[1]), .gpio_pin_53(pin[2]), .gpio_pin_54(pin[3]), .standby_por(por),
      .system_power_on_out_n(pwr_n), .group_mgmt_irq_out_n, .group_mgmt_irq_oe,
      .frame_slot_irq, .group_to_wake, .sci_pulse, .either_edge_irq, .gpio_data,
      .gpio_pin_oe, .gpio_pin_out);
   gsi_host_model host_u (.ref_clk, .group_mgmt_irq_out_n, .group_mgmt_irq_oe,
      .frame_slot_irq, .pin_level, .smi_taken_reg);
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // strobes get an idle edge after them so back-to-back calls never reassign
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      chk(reg_rdata, e);
   endtask : rd
   task automatic give_verdict();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      tick(3);
      arst_n = 1'b1;
      // reset values, reserved bits, unmapped place
      rd(GSI_OFF_ENABLE_A, GSI_RST_ENABLE_A);
      rd(GSI_OFF_ENABLE_B, GSI_RST_ENABLE_B);
      rd(GSI_OFF_EDGE_STS, GSI_RST_EDGE_STS);
      wr(8'h17, 8'hff);
      rd(8'h17, 8'h00);
      wr(GSI_OFF_ENABLE_B, 8'hff);
      rd(GSI_OFF_ENABLE_B, 8'hdf);
      wr(GSI_OFF_EDGE_STS, 8'hff);
      rd(GSI_OFF_EDGE_STS, 8'h00);
      // each source alone: routed, then output gated off, then enable off
      for (i = 0; i < 13; i++) begin
         wr(GSI_OFF_ENABLE_A, (i < 8) ? 8'(1 << i) : 8'h00);
         wr(GSI_OFF_ENABLE_B, (i < 8) ? 8'hc0 : 8'(8'hc0 | (1 << (i - 8))));
         src = 13'(1 << i);
         tick(2);
         chk(8'({group_mgmt_irq_out_n, group_mgmt_irq_oe, group_to_wake, pin_level,
            smi_taken_reg}), 8'h0d);
         wr(GSI_OFF_ENABLE_B, (i < 8) ? 8'h00 : 8'(1 << (i - 8)));
         tick(2);
         chk(8'({group_mgmt_irq_out_n, group_mgmt_irq_oe, group_to_wake, pin_level}),
            8'h09);
         wr(GSI_OFF_ENABLE_A, 8'h00);
         wr(GSI_OFF_ENABLE_B, 8'h80);
         chk(8'({group_mgmt_irq_out_n, pin_level}), 8'h03);
         src = 13'h0;
      end
      other = 1'b1;
      tick(2);
      chk(8'(group_mgmt_irq_out_n), 8'h00);
      other = 1'b0;
      wr(GSI_OFF_ENABLE_A, 8'h08);
      fsel = 1'b1;
      src = 13'h8;
      tick(2);
      chk(8'({frame_slot_irq, smi_taken_reg}), 8'h03);
      fsel = 1'b0;
      src = 13'h0;
      // either-edge: rising pass then falling pass on all four pins
      wr(GSI_OFF_ENABLE_B, 8'h00);
      wr(GSI_OFF_ENABLE_A, 8'h60);
      sel = 4'hf;
      pol = 4'h5;
      for (k = 0; k < 8; k++) begin
         i = k % 4;
         pin[i] = ~pin[i];
         tick(5);
         chk(8'(either_edge_irq), 8'(1 << i));
         chk(8'({gpio_data, gpio_pin_oe}), 8'({pin ^ pol, 4'h0}));
         chk(8'(gpio_pin_out), 8'h00);
         rd(GSI_OFF_EDGE_STS, 8'(1 << i));
         wr(GSI_OFF_EDGE_STS, 8'(1 << i));
         rd(GSI_OFF_EDGE_STS, 8'h00);
         chk(8'(either_edge_irq), 8'h00);
      end
      // edges still recorded with mode and group off
      wr(GSI_OFF_ENABLE_A, 8'h00);
      sel = 4'h0;
      pin = ~pin;
      tick(5);
      chk(8'(either_edge_irq), 8'h00);
      chk(8'({gpio_pin_oe, gpio_pin_out}), 8'hfa);
      wr(GSI_OFF_EDGE_STS, 8'h00);
      rd(GSI_OFF_EDGE_STS, 8'h0f);
      sel = 4'hf;
      wr(GSI_OFF_ENABLE_A, 8'h40);
      chk(8'(either_edge_irq), 8'h03);
      chk(8'({gpio_pin_oe, gpio_pin_out}), 8'hc8);
      wr(GSI_OFF_EDGE_STS, 8'h0f);
      // standby power-on, then system power-on raises one sci
      por = 1'b1;
      tick(4);
      rd(GSI_OFF_EDGE_STS, 8'h10);
      pwr_n = 1'b0;
      k = 0;
      for (i = 0; i < 8; i++) begin
         tick(1);
         k += (sci_pulse === 1'b1);
      end
      chk(8'(k), 8'h01);
      wr(GSI_OFF_EDGE_STS, 8'h10);
      rd(GSI_OFF_EDGE_STS, 8'h00);
      give_verdict();
   end
   // whole sequence runs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      give_verdict();
   end
endmodule : gsi_group_irq_test
`default_nettype wire
